// *** hdl/audio_codec_ctrl_regs.sv ***
/*
 * Audio control word and record volume word of the codec, with decoded
 * clocking, format and preamp outputs and two soft-stepped record gains.
 * Assumes a word-wide register port driven on the same clock by the serial
 * control front end, which has already selected the audio page.
 * It also assumes the analog side acts on the level and tie outputs
 * directly, with no smoothing of its own.
 */
`timescale 1ns/1ps
`default_nettype none
`include "audio_codec_ctrl_consts.svh"

module audio_codec_ctrl_regs
    import audio_codec_ctrl_pkg::*;
#(
    parameter int CLK_HZ = `ACR_CLK_HZ
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr_en,
    input wire logic i_reg_rd_en,
    input wire logic [5:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rd_valid,
    output logic [1:0] o_mic_preamp_gain_sel,
    output logic [3:0] o_mic_preamp_gain_db,
    output logic [1:0] o_mclk_ratio_sel,
    output logic [9:0] o_mclk_ratio,
    output logic [3:0] o_sample_rate_sel,
    output logic o_sample_rate_bad,
    output logic [1:0] o_audio_data_format_sel,
    output logic [4:0] o_play_word_bits,
    output logic [1:0] o_play_just,
    output logic [4:0] o_rec_word_bits,
    output logic [1:0] o_rec_just,
    output logic o_sample_tick,
    output logic [6:0] o_left_pga_level,
    output logic [6:0] o_right_pga_level,
    output logic o_left_common_mode_reference_tie,
    output logic o_right_common_mode_reference_tie
);
    // ---------------------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------------------
    // whole words are kept, filter and mux bits too,
    // so a read returns what software last wrote
    logic [15:0] audio_control_r, audio_control_nxt;           // audio control word
    logic [15:0] adc_volume_control_r, adc_volume_control_nxt; // record volume word
    logic [15:0] rdata_r, rdata_nxt;                           // read answer
    logic rd_valid_r, rd_valid_nxt;                            // read answer strobe

    // ---------------------------------------------------------------------------
    // decoded field state
    // ---------------------------------------------------------------------------
    // registered decodes cannot glitch while a word
    // lands; the price is one clock of lag
    logic [1:0] mic_preamp_gain_sel;    // field view, wire
    logic [1:0] mclk_ratio_sel;         // field view, wire
    logic [3:0] sample_rate_sel;        // field view, wire
    logic [1:0] audio_data_format_sel;  // field view, wire
    logic [3:0] mic_db_r, mic_db_nxt;   // preamp gain in dB
    logic [9:0] ratio_r, ratio_nxt;     // master clock over sample rate
    logic rate_bad_r, rate_bad_nxt;     // host wrote an unlisted rate
    logic [4:0] play_bits_r, play_bits_nxt;
    logic [4:0] rec_bits_r, rec_bits_nxt;
    just_type play_just_r, play_just_nxt;
    just_type rec_just_r, rec_just_nxt;

    // ---------------------------------------------------------------------------
    // channel wiring
    // ---------------------------------------------------------------------------
    // arrays let one generate loop serve both sides;
    // level and tie return through each carrier
    logic tick;              // one pulse per sample
    logic [6:0] pga_level [2]; // index 0 left, 1 right
    logic pga_muted [2];
    logic left_mute;         // left mute bit
    logic right_mute;        // right mute bit
    logic [6:0] left_gain_code;
    logic [6:0] right_gain_code;

    // field views; the stored word is the only state
    assign mic_preamp_gain_sel = audio_control_r[`ACR_MIC_PREAMP_GAIN_SEL_LSB +: 2];
    assign mclk_ratio_sel = audio_control_r[`ACR_MCLK_LSB +: 2];
    assign sample_rate_sel = audio_control_r[`ACR_FS_LSB +: 4];
    assign audio_data_format_sel = audio_control_r[`ACR_FMT_LSB +: 2];
    assign left_mute = adc_volume_control_r[`ACR_LMUTE_BIT];
    assign left_gain_code = adc_volume_control_r[`ACR_LGAIN_LSB +: 7];
    assign right_mute = adc_volume_control_r[`ACR_RMUTE_BIT];
    assign right_gain_code = adc_volume_control_r[`ACR_RGAIN_LSB +: 7];

    // ---------------------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------------------
    // no wait states: a strobe is taken on its edge
    // writes store whole words; the mute bit never touches the stored gain
    // code, so an unmute returns to what software last wrote unless that code is under the floor
    always_comb begin
        // defaults: hold words and answer, no strobe
        audio_control_nxt = audio_control_r;
        adc_volume_control_nxt = adc_volume_control_r;
        rdata_nxt = rdata_r;
        rd_valid_nxt = 1'b0;
        // writes to unmapped offsets are dropped
        if (i_reg_wr_en) begin
            if (i_reg_addr == `ACR_ADDR_AUDIO_CTRL) begin
                audio_control_nxt = i_reg_wdata;
            end else if (i_reg_addr == `ACR_ADDR_ADC_VOL) begin
                adc_volume_control_nxt = i_reg_wdata;
            end
        end
        // a read beside a write shows the old word
        if (i_reg_rd_en) begin
            // unmapped offsets read as zero
            // but still answer, so no read is left waiting
            rd_valid_nxt = 1'b1;
            if (i_reg_addr == `ACR_ADDR_AUDIO_CTRL) begin
                rdata_nxt = audio_control_r;
            end else if (i_reg_addr == `ACR_ADDR_ADC_VOL) begin
                rdata_nxt = adc_volume_control_r;
            end else begin
                rdata_nxt = 16'h0000;
            end
        end
    end

    // registers only; mute bits and unity codes come up from reset
    // so both inputs start tied; the read answer
    // holds until the next read
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            audio_control_r <= `ACR_AUDIO_CTRL_RST;
            adc_volume_control_r <= `ACR_ADC_VOL_RST;
            rdata_r <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else begin
            audio_control_r <= audio_control_nxt;
            adc_volume_control_r <= adc_volume_control_nxt;
            rdata_r <= rdata_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    // ---------------------------------------------------------------------------
    // field decode
    // ---------------------------------------------------------------------------
    // decoded values follow the stored word by one clock
    always_comb begin
        // preamp: both low codes are 0 dB
        unique case (mic_preamp_gain_sel)
            2'h2: mic_db_nxt = `ACR_MIC_DB_6;
            2'h3: mic_db_nxt = `ACR_MIC_DB_12;
            default: mic_db_nxt = `ACR_MIC_DB_0;
        endcase
        // master clock ratio: code 11 repeats 256
        // the ratio leaves as a plain multiple of the rate
        unique case (mclk_ratio_sel)
            2'h1: ratio_nxt = `ACR_MCLK_384;
            2'h2: ratio_nxt = `ACR_MCLK_512;
            default: ratio_nxt = `ACR_MCLK_256;
        endcase
        // an unlisted rate is the host's fault; flag it, clocks use 48 kHz
        // the flag is a level; a valid rate clears it
        rate_bad_nxt = (sample_rate_sel > `ACR_FS_MAX_CODE);
        // serial format of playback and record paths
        // code 11, the reset format, takes the default arm
        unique case (audio_data_format_sel)
            2'h0: begin
                play_bits_nxt = `ACR_WORD_16;
                play_just_nxt = just_right;
                rec_bits_nxt = `ACR_WORD_16;
                rec_just_nxt = just_left;
            end
            2'h1: begin
                play_bits_nxt = `ACR_WORD_20;
                play_just_nxt = just_right;
                rec_bits_nxt = `ACR_WORD_20;
                rec_just_nxt = just_left;
            end
            2'h2: begin
                play_bits_nxt = `ACR_WORD_20;
                play_just_nxt = just_left;
                rec_bits_nxt = `ACR_WORD_20;
                rec_just_nxt = just_left;
            end
            default: begin
                play_bits_nxt = `ACR_WORD_20;
                play_just_nxt = just_i2s;
                rec_bits_nxt = `ACR_WORD_20;
                rec_just_nxt = just_i2s;
            end
        endcase
    end

    // registers only; values match the reset word's decode
    // so no false change shows after reset
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mic_db_r <= `ACR_MIC_DB_0;
            ratio_r <= `ACR_MCLK_256;
            rate_bad_r <= 1'b0;
            play_bits_r <= `ACR_WORD_20;
            play_just_r <= just_i2s;
            rec_bits_r <= `ACR_WORD_20;
            rec_just_r <= just_i2s;
        end else begin
            mic_db_r <= mic_db_nxt;
            ratio_r <= ratio_nxt;
            rate_bad_r <= rate_bad_nxt;
            play_bits_r <= play_bits_nxt;
            play_just_r <= play_just_nxt;
            rec_bits_r <= rec_bits_nxt;
            rec_just_r <= rec_just_nxt;
        end
    end

    // ---------------------------------------------------------------------------
    // sample clocking
    // ---------------------------------------------------------------------------
    // pacing the ramps per sample keeps each step inaudible at any rate
    // one tick source keeps both channels in step;
    // an unlisted rate paces the ramps as 48 kHz;
    // a new rate takes hold within the running period
    sample_tick #(
        .CLK_HZ(CLK_HZ)
    ) u_sample_tick (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_rate_sel(sample_rate_sel),
        .o_tick(tick)
    );

    // ---------------------------------------------------------------------------
    // record gain channels
    // ---------------------------------------------------------------------------
    // both channels share one encoding; codes under the floor count as mute
    // mute bit and low code merge into one request,
    // so both ways of muting walk the same path;
    // index 0 is left, index 1 right
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            // each channel gets a carrier of its own
            ramp_if rif();
            assign rif.target = (ch == 0) ? left_gain_code : right_gain_code;
            assign rif.mute_req = (ch == 0)
                ? (left_mute || left_gain_code < `ACR_GAIN_FLOOR)
                : (right_mute || right_gain_code < `ACR_GAIN_FLOOR);
            assign rif.tick = tick;
            gain_ramp u_gain_ramp (
                .i_ref_clk(i_ref_clk),
                .i_rst_n(i_rst_n),
                .rp(rif.ramp)
            );
            assign pga_level[ch] = rif.level;
            assign pga_muted[ch] = rif.muted;
        end
    endgenerate

    // ---------------------------------------------------------------------------
    // outputs, all from flip-flops
    // selects come straight from the stored word,
    // decodes lag it by one clock; the tie outputs
    // switch the record inputs to the common mode
    // ---------------------------------------------------------------------------
    assign o_reg_rdata = rdata_r;
    assign o_reg_rd_valid = rd_valid_r;
    assign o_mic_preamp_gain_sel = audio_control_r[`ACR_MIC_PREAMP_GAIN_SEL_LSB +: 2];
    assign o_mic_preamp_gain_db = mic_db_r;
    assign o_mclk_ratio_sel = audio_control_r[`ACR_MCLK_LSB +: 2];
    assign o_mclk_ratio = ratio_r;
    assign o_sample_rate_sel = audio_control_r[`ACR_FS_LSB +: 4];
    assign o_sample_rate_bad = rate_bad_r;
    assign o_audio_data_format_sel = audio_control_r[`ACR_FMT_LSB +: 2];
    assign o_play_word_bits = play_bits_r;
    assign o_play_just = play_just_r;
    assign o_rec_word_bits = rec_bits_r;
    assign o_rec_just = rec_just_r;
    assign o_sample_tick = tick;
    assign o_left_pga_level = pga_level[0];
    assign o_right_pga_level = pga_level[1];
    assign o_left_common_mode_reference_tie = pga_muted[0];
    assign o_right_common_mode_reference_tie = pga_muted[1];
endmodule
`default_nettype wire

// *** hdl/gain_ramp.sv ***
/*
 * One soft-stepped record gain channel with mute ramp.
 * Assumes target and mute request are stable registers on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "audio_codec_ctrl_consts.svh"
module gain_ramp
    import audio_codec_ctrl_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    ramp_if.ramp rp
);
    ramp_state_type state_r, state_nxt; // live or tied to common mode
    logic [6:0] level_r, level_nxt;     // applied gain code
    logic muted_r, muted_nxt;           // registered copy of the silent state

    // ---------------------------------------------------------------------------
    // stepping
    // ---------------------------------------------------------------------------
    // one half-dB step per sample tick, never a jump
    always_comb begin
        state_nxt = state_r;
        level_nxt = level_r;
        unique case (state_r)
            ramp_live: begin
                if (rp.mute_req) begin
                    // walk down to the floor, then cut the input
                    if (level_r <= `ACR_GAIN_FLOOR) begin
                        state_nxt = ramp_silent;
                    end else if (rp.tick) begin
                        level_nxt = level_r - 7'h01;
                    end
                end else if (rp.tick && level_r != rp.target) begin
                    // toward the written code, either direction
                    if (level_r < rp.target) begin
                        level_nxt = level_r + 7'h01;
                    end else begin
                        level_nxt = level_r - 7'h01;
                    end
                end
            end
            ramp_silent: begin
                // release the tie, then climb from the floor
                if (!rp.mute_req) begin
                    state_nxt = ramp_live;
                end
            end
        endcase
        muted_nxt = (state_nxt == ramp_silent);
    end

    // registers only; channel starts tied at the floor
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ramp_silent;
            level_r <= `ACR_GAIN_FLOOR;
            muted_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            level_r <= level_nxt;
            muted_r <= muted_nxt;
        end
    end

    assign rp.level = level_r;
    assign rp.muted = muted_r;
endmodule
`default_nettype wire

// *** hdl/sample_tick.sv ***
/*
 * Sample-period pulse generator for the selected converter rate.
 * Assumes a free-running reference clock of CLK_HZ.
 */
`timescale 1ns/1ps
`default_nettype none
`include "audio_codec_ctrl_consts.svh"
module sample_tick #(
    parameter int CLK_HZ = `ACR_CLK_HZ
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_rate_sel,
    output logic o_tick
);
    // ---------------------------------------------------------------------------
    // period lookup
    // ---------------------------------------------------------------------------
    // cycles per sample, rounded down; invalid codes fall back to 48 kHz
    function automatic logic [15:0] period_of(input logic [3:0] sel);
        int hz;
        int cyc;
        unique case (sel)
            4'h1: hz = `ACR_FS_44K1_HZ;
            4'h2: hz = `ACR_FS_32K_HZ;
            4'h3: hz = `ACR_FS_24K_HZ;
            4'h4: hz = `ACR_FS_22K05_HZ;
            4'h5: hz = `ACR_FS_16K_HZ;
            4'h6: hz = `ACR_FS_12K_HZ;
            4'h7: hz = `ACR_FS_11K05_HZ;
            4'h8: hz = `ACR_FS_8K_HZ;
            default: hz = `ACR_FS_48K_HZ;
        endcase
        cyc = CLK_HZ / hz;
        if (cyc < 1) begin
            cyc = 1;
        end
        return cyc[15:0];
    endfunction

    logic [15:0] cnt_r, cnt_nxt; // cycles into the current sample
    logic tick_r, tick_nxt;      // registered pulse

    // next count; compare with >= so a rate change never strands the counter
    always_comb begin
        cnt_nxt = cnt_r + 16'h0001;
        tick_nxt = 1'b0;
        if (cnt_nxt >= period_of(i_rate_sel)) begin
            cnt_nxt = 16'h0000;
            tick_nxt = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign o_tick = tick_r;
endmodule
`default_nettype wire

// *** include/audio_codec_ctrl_consts.svh ***
/*
 * Register offsets, field positions, reset words and timing figures of the
 * codec configuration register slice.
 * Assumes it is included by bare name from design files only.
 */
`ifndef AUDIO_CODEC_CTRL_CONSTS_SVH
`define AUDIO_CODEC_CTRL_CONSTS_SVH

// ---------------------------------------------------------------------------
// register offsets within the audio page
// ---------------------------------------------------------------------------
`define ACR_ADDR_AUDIO_CTRL 6'h00
`define ACR_ADDR_ADC_VOL 6'h01

// ---------------------------------------------------------------------------
// reset words
// ---------------------------------------------------------------------------
// filter bits 15:14 = 11, muxes 00, preamp 0 dB, 256 fs, 48 kHz, 20-bit i2s
`define ACR_AUDIO_CTRL_RST 16'hc003
// both mute bits set, both gain codes at unity
`define ACR_ADC_VOL_RST 16'hd7d7

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define ACR_MIC_PREAMP_GAIN_SEL_LSB 8
`define ACR_MCLK_LSB 6
`define ACR_FS_LSB 2
`define ACR_FMT_LSB 0
`define ACR_LMUTE_BIT 15
`define ACR_LGAIN_LSB 8
`define ACR_RMUTE_BIT 7
`define ACR_RGAIN_LSB 0

// ---------------------------------------------------------------------------
// field values
// ---------------------------------------------------------------------------
`define ACR_GAIN_FLOOR 7'h07
`define ACR_GAIN_UNITY 7'h57
`define ACR_FS_MAX_CODE 4'h8
`define ACR_MIC_DB_0 4'h0
`define ACR_MIC_DB_6 4'h6
`define ACR_MIC_DB_12 4'hc
`define ACR_MCLK_256 10'h100
`define ACR_MCLK_384 10'h180
`define ACR_MCLK_512 10'h200
`define ACR_WORD_16 5'h10
`define ACR_WORD_20 5'h14

// ---------------------------------------------------------------------------
// clock and sample rates in hertz
// ---------------------------------------------------------------------------
`define ACR_CLK_HZ 32'h02faf080
`define ACR_FS_48K_HZ 32'h0000bb80
`define ACR_FS_44K1_HZ 32'h0000ac44
`define ACR_FS_32K_HZ 32'h00007d00
`define ACR_FS_24K_HZ 32'h00005dc0
`define ACR_FS_22K05_HZ 32'h00005622
`define ACR_FS_16K_HZ 32'h00003e80
`define ACR_FS_12K_HZ 32'h00002ee0
`define ACR_FS_11K05_HZ 32'h00002b2a
`define ACR_FS_8K_HZ 32'h00001f40

`endif

// *** include/audio_codec_ctrl_pkg.sv ***
/*
 * Types shared by the codec configuration register slice.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package audio_codec_ctrl_pkg;
    // serial word justification on one audio path
    typedef enum logic [1:0] {just_right, just_left, just_i2s} just_type;
    // soft-step channel state: gain live, or input tied to common mode
    typedef enum logic {ramp_live, ramp_silent} ramp_state_type;
endpackage

// *** include/ramp_if.sv ***
/*
 * Carrier between the register slice and one soft-step gain channel.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface ramp_if;
    logic [6:0] target;   // gain code held in the register
    logic mute_req;       // mute bit or code below floor
    logic tick;           // one pulse per sample period
    logic [6:0] level;    // gain code presently applied
    logic muted;          // input tied to common mode
    modport ctrl(output target, output mute_req, output tick, input level, input muted);
    modport ramp(input target, input mute_req, input tick, output level, output muted);
endinterface
`default_nettype wire

// *** tb/ctrl_regs_monitor.sv ***
/*
 * Port assertions for the codec register slice.
 * Assumes a bind onto the top module, one clock, async low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module ctrl_regs_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] o_mic_preamp_gain_sel,
    input wire logic [3:0] o_mic_preamp_gain_db,
    input wire logic [1:0] o_mclk_ratio_sel,
    input wire logic [9:0] o_mclk_ratio,
    input wire logic [3:0] o_sample_rate_sel,
    input wire logic o_sample_rate_bad,
    input wire logic [1:0] o_audio_data_format_sel,
    input wire logic [4:0] o_play_word_bits,
    input wire logic o_sample_tick,
    input wire logic [6:0] o_left_pga_level,
    input wire logic [6:0] o_right_pga_level,
    input wire logic o_left_common_mode_reference_tie
);
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // decoded outputs may lag the field by a cycle, so only judge settled fields
    a_mic_db_map: assert property ($stable(o_mic_preamp_gain_sel) |-> o_mic_preamp_gain_db ==
        (o_mic_preamp_gain_sel == 2'h3 ? 4'hc : o_mic_preamp_gain_sel == 2'h2 ? 4'h6 : 4'h0)) else $error("mic db");
    a_mclk_map: assert property ($stable(o_mclk_ratio_sel) |-> o_mclk_ratio ==
        (o_mclk_ratio_sel == 2'h1 ? 10'h180 : o_mclk_ratio_sel == 2'h2 ? 10'h200 : 10'h100)) else $error("mclk");
    a_rate_flag: assert property ($stable(o_sample_rate_sel) |->
        o_sample_rate_bad == (o_sample_rate_sel > 4'h8)) else $error("rate flag");
    a_word_bits: assert property ($stable(o_audio_data_format_sel) |->
        o_play_word_bits == (o_audio_data_format_sel == 2'h0 ? 5'h10 : 5'h14)) else $error("word bits");
    a_step_one: assert property ($changed(o_left_pga_level) |->
        (o_left_pga_level == $past(o_left_pga_level) + 7'h1 || o_left_pga_level == $past(o_left_pga_level) - 7'h1))
        else $error("gain jump");
    a_step_on_tick: assert property ($changed(o_left_pga_level) |-> $past(o_sample_tick)) else $error("step w/o tick");
    a_tick_pulse: assert property (o_sample_tick |=> !o_sample_tick) else $error("tick too long");
    a_gain_floor: assert property (o_left_pga_level >= 7'h07) else $error("below floor");
    a_tie_floor: assert property (o_left_common_mode_reference_tie |-> o_left_pga_level == 7'h07)
        else $error("tied above floor");
    a_right_step: assert property ($changed(o_right_pga_level) |->
        (o_right_pga_level == $past(o_right_pga_level) + 7'h1 ||
        o_right_pga_level == $past(o_right_pga_level) - 7'h1)) else $error("right gain jump");
    c_tie_fall: cover property ($fell(o_left_common_mode_reference_tie));
    c_tie_rise: cover property ($rose(o_left_common_mode_reference_tie));
    c_rate_bad: cover property (o_sample_rate_bad);
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
/*
 * Self-checking bench for the codec register slice.
 * Assumes the package, interface and design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ----------
    // signals
    // ----------
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_reg_wr_en = 1'b0;
    logic i_reg_rd_en = 1'b0;
    logic [5:0] i_reg_addr = 6'h00;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic [15:0] o_reg_rdata;
    logic o_reg_rd_valid, o_sample_rate_bad, o_sample_tick;
    logic o_left_common_mode_reference_tie, o_right_common_mode_reference_tie;
    logic [1:0] o_mic_preamp_gain_sel, o_mclk_ratio_sel, o_audio_data_format_sel, o_play_just, o_rec_just;
    logic [3:0] o_mic_preamp_gain_db, o_sample_rate_sel;
    logic [9:0] o_mclk_ratio;
    logic [4:0] o_play_word_bits, o_rec_word_bits;
    logic [6:0] o_left_pga_level, o_right_pga_level;
    int n_errors = 0;
    int checks = 0;
    // 48 kHz gives a 10-cycle sample period, 8 kHz gives 60
    audio_codec_ctrl_regs #(.CLK_HZ(480000)) dut_u (.*);
    initial forever #10 i_ref_clk = ~i_ref_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge i_ref_clk);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr_en = 1'b1;
        @(negedge i_ref_clk);
        i_reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        @(negedge i_ref_clk);
        i_reg_addr = a;
        i_reg_rd_en = 1'b1;
        @(negedge i_ref_clk);
        i_reg_rd_en = 1'b0;
        chk({o_reg_rd_valid, o_reg_rdata}, {1'b1, exp});
    endtask
    // bounded wait for both channels to reach a level and tie state
    task automatic settle(input logic [6:0] l, input logic [6:0] r, input logic lt, input logic rt);
        int i;
        for (i = 0; i < 3000 && {o_left_pga_level, o_right_pga_level, o_left_common_mode_reference_tie,
            o_right_common_mode_reference_tie} !== {l, r, lt, rt}; i++) @(negedge i_ref_clk);
        chk({o_left_pga_level, o_right_pga_level, o_left_common_mode_reference_tie,
            o_right_common_mode_reference_tie}, {l, r, lt, rt});
        if (i == 3000) tally_and_finish();
    endtask
    // first gaps may straddle a rate change, so the third gap is judged
    task automatic tick_gap(input int exp);
        int n;
        int k;
        for (k = 0; k < 3; k++) begin
            @(negedge i_ref_clk);
            for (n = 1; n < 200 && o_sample_tick !== 1'b1; n++) @(negedge i_ref_clk);
            if (n == 200) begin
                chk(32'(n), 32'(exp));
                tally_and_finish();
            end
        end
        chk(32'(n), 32'(exp));
    endtask
    task automatic t_reset();
        rd(6'h00, 16'hc003);
        rd(6'h01, 16'hd7d7);
        chk({o_mic_preamp_gain_db, o_mclk_ratio, o_play_word_bits, o_play_just}, {4'h0, 10'h100, 5'h14, 2'h2});
        settle(7'h07, 7'h07, 1'b1, 1'b1);
    endtask
    task automatic t_fields();
        logic [27:0] t [4] = '{{4'h0, 10'h100, 5'h10, 5'h10, 2'h0, 2'h1}, {4'h0, 10'h180, 5'h14, 5'h14, 2'h0, 2'h1},
            {4'h6, 10'h200, 5'h14, 5'h14, 2'h1, 2'h1}, {4'hc, 10'h100, 5'h14, 5'h14, 2'h2, 2'h2}};
        logic [1:0] c;
        int per [9] = '{10, 10, 15, 20, 21, 30, 40, 43, 60}; // CLK_HZ over each rate
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr(6'h00, {6'h30, c, c, 2'h0, c, c});
            repeat (3) @(negedge i_ref_clk);
            chk({o_mic_preamp_gain_db, o_mclk_ratio, o_play_word_bits, o_rec_word_bits, o_play_just, o_rec_just},
                t[i]);
            chk({o_mic_preamp_gain_sel, o_mclk_ratio_sel, o_sample_rate_sel, o_audio_data_format_sel},
                {c, c, 2'h0, c, c});
            rd(6'h00, {6'h30, c, c, 2'h0, c, c});
        end
        for (int r = 0; r < 9; r++) begin
            wr(6'h00, {10'h300, 4'(r), 2'h3});
            tick_gap(per[r]);
        end
        wr(6'h00, 16'hc027);
        tick_gap(10);
        chk(o_sample_rate_bad, 1'b1);
        wr(6'h00, 16'hc003);
        rd(6'h02, 16'h0000);
        chk(o_sample_rate_bad, 1'b0);
    endtask
    task automatic t_ramp();
        wr(6'h01, 16'h0c57);
        settle(7'h0c, 7'h57, 1'b0, 1'b0);
        wr(6'h01, 16'h03d7);
        settle(7'h07, 7'h07, 1'b1, 1'b1);
        rd(6'h01, 16'h03d7);
        wr(6'h01, 16'h8c57);
        settle(7'h07, 7'h57, 1'b1, 1'b0);
        rd(6'h01, 16'h8c57);
        wr(6'h01, 16'h0c57);
        settle(7'h0c, 7'h57, 1'b0, 1'b0);
        wr(6'h01, 16'h0a57);
        settle(7'h0a, 7'h57, 1'b0, 1'b0);
    endtask
    task automatic tally_and_finish();
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        t_reset();
        t_fields();
        t_ramp();
        tally_and_finish();
    end
endmodule
bind audio_codec_ctrl_regs ctrl_regs_monitor mon_u (.*);
`default_nettype wire
